// file: design/pio_top.sv
// Operation
// - Digital output follows written one or zero
// - Analog registers carry 22 mA full-scale codes
// - Frequency mode reports input hertz
// - Input counter spans two 16-bit words
// - Lower input word counts up to 32767
// - Coil rising edge alone clears input count
// - Output frequency equals lower word hertz
// - Frequency mode ignores upper word writes
// - Output count spans two 16-bit words
// - Absolute mode emits new minus previous
// - Absolute count below previous wraps through zero
// - Differential mode emits written count
// - Control word pair selects counting type
// - Zero and -32768 pair clears output
// - New counts add to pending total
// - Analog output holds or drops on link loss
// - Digital output holds or opens on link loss
// - Count kept, counting needs some power
// - Frequency is pulses per one second
// - Low speed needs 70 ms pulse width
// - High speed needs 10 us pulse width
// - Counter pulses 50 percent at 10 kHz/10 Hz
// - Output stops when power is lost
`timescale 1ns/1ps
`include "pio_cfg.svh"
module pio_top #(
  parameter int LS_MIN_CYC  = `PIO_LS_MIN_CYC,  // Low speed width filter
  parameter int WINDOW_CYC  = `PIO_WINDOW_CYC,  // Frequency gate time
  parameter int HS_HALF_CYC = `PIO_HS_HALF_CYC, // 10 kHz half period
  parameter int LS_HALF_CYC = `PIO_LS_HALF_CYC  // 10 Hz half period
) (
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire pio_pkg::pio_axi_req_t axi_req,
  output pio_pkg::pio_axi_rsp_t     axi_rsp,
  input  wire logic [1:0]           pulse_in,
  input  wire logic                 primary_ok,
  input  wire logic                 backup_ok,
  input  wire logic                 out_power_ok,
  input  wire logic                 link_ok,
  input  wire logic [7:0]           dout_fail_open,
  input  wire logic [3:0]           aout_fail_low,
  input  wire logic [3:0][15:0]     ain,
  output logic [1:0]                pulse_out,
  output logic [7:0]                dout,
  output logic [3:0][15:0]          aout
);

  pio_pkg::pio_state_t s;      // Registered state
  pio_pkg::pio_state_t next_s; // Next state

  logic wr_go;  // Write address and data taken together
  logic rd_go;  // Read address taken

  // Handshakes: one write and one read in flight, answer one cycle later
  assign wr_go = axi_req.awvalid && axi_req.wvalid && !s.bvalid;
  assign rd_go = axi_req.arvalid && !s.rvalid;

  // Bus answers
  always_comb begin
    axi_rsp.awready = wr_go;
    axi_rsp.wready  = wr_go;
    axi_rsp.bvalid  = s.bvalid;
    axi_rsp.bresp   = s.bresp;
    axi_rsp.arready = rd_go;
    axi_rsp.rvalid  = s.rvalid;
    axi_rsp.rdata   = s.rdata;
    axi_rsp.rresp   = s.rresp;
  end

  // Pin outputs all come straight from flops
  assign pulse_out = s.pout;
  assign dout      = s.dout;
  assign aout      = s.aout;

  // Byte-lane merge for a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0]  strb);
    logic [15:0] r;
    r = old;
    if (strb[0]) r[7:0]  = d[7:0];
    if (strb[1]) r[15:8] = d[15:8];
    return r;
  endfunction : merge16

  // All next-state logic
  always_comb begin
    logic [7:0]  wa;       // Write byte address
    logic [7:0]  ra;       // Read byte address
    logic        whit;     // Write hit a register
    logic        rhit;     // Read hit a register
    logic [7:0]  base;     // Channel block base
    logic [31:0] newc;     // Committed output count
    logic [15:0] wl;       // Merged lower word
    logic        counting; // Input side powered
    logic        qual;     // Width filter met
    logic        hs;       // High speed selected
    logic [27:0] ph;       // Phase sum
    logic [31:0] half;     // Half period in cycles, minus one
    wa       = axi_req.awaddr[7:0];
    ra       = axi_req.araddr[7:0];
    whit     = 1'b0;
    rhit     = 1'b0;
    base     = '0;
    newc     = '0;
    wl       = '0;
    counting = primary_ok || backup_ok;
    qual     = 1'b0;
    hs       = 1'b0;
    ph       = '0;
    half     = '0;
    next_s   = s;

    // Answers retire when the master takes them
    if (s.bvalid && axi_req.bready) begin
      next_s.bvalid = 1'b0;
    end
    if (s.rvalid && axi_req.rready) begin
      next_s.rvalid = 1'b0;
    end

    // One-second gate shared by both frequency inputs
    if (s.sec_cnt >= 32'(WINDOW_CYC - 1)) begin
      next_s.sec_cnt = '0;
    end else begin
      next_s.sec_cnt = s.sec_cnt + 32'h1;
    end

    // Pulse input channels
    for (int c = 0; c < 2; c++) begin
      hs   = s.ctrl[`PIO_C_INHS + c];
      qual = 1'b0;  // Fresh per channel, so one pin never counts for the other
      // Width filter: the pin must differ for the whole minimum width
      if (pulse_in[c] == s.in_lvl[c]) begin
        next_s.in_flt[c] = '0;
      end else begin
        next_s.in_flt[c] = s.in_flt[c] + 32'h1;
        qual = hs ? (s.in_flt[c] >= 32'(`PIO_HS_MIN_CYC - 1))
                  : (s.in_flt[c] >= 32'(LS_MIN_CYC - 1));
        if (qual) begin
          next_s.in_lvl[c] = pulse_in[c];
          next_s.in_flt[c] = '0;
        end
      end
      // Count on the qualified rising edge, only while powered
      if (qual && pulse_in[c] && counting) begin
        if (s.in_lsw[c] >= `PIO_CNT_MAX) begin
          next_s.in_lsw[c] = '0;
          next_s.in_msw[c] = s.in_msw[c] + 16'h1;
        end else begin
          next_s.in_lsw[c] = s.in_lsw[c] + 16'h1;
        end
        if (s.in_facc[c] != 16'hffff) begin
          next_s.in_facc[c] = s.in_facc[c] + 16'h1;
        end
      end
      // Latch the pulses seen in the last second as hertz
      if (s.sec_cnt >= 32'(WINDOW_CYC - 1)) begin
        next_s.in_freq[c] = next_s.in_facc[c];
        next_s.in_facc[c] = '0;
      end
    end

    // Pulse output channels
    for (int c = 0; c < 2; c++) begin
      hs   = s.ctrl[`PIO_C_OUTHS + c];
      half = hs ? 32'(HS_HALF_CYC - 1) : 32'(LS_HALF_CYC - 1);
      if (!out_power_ok) begin
        // No power: the pin rests low, pending counts wait
        next_s.pout[c]     = 1'b0;
        next_s.gen[c]      = pio_pkg::PIO_GEN_IDLE;
        next_s.phase[c]    = '0;
        next_s.half_cnt[c] = '0;
      end else if (s.ctrl[`PIO_C_OUTFREQ + c]) begin
        // Phase accumulator: toggles twice per period on average
        next_s.gen[c] = pio_pkg::PIO_GEN_IDLE;
        if (s.out_lsw[c] == '0) begin
          next_s.pout[c]  = 1'b0;
          next_s.phase[c] = '0;
        end else begin
          ph = {1'b0, s.phase[c]} + {11'h0, s.out_lsw[c], 1'b0};
          if (ph >= {1'b0, `PIO_CLK_HZ}) begin
            ph = ph - {1'b0, `PIO_CLK_HZ};
            next_s.pout[c] = !s.pout[c];
          end
          next_s.phase[c] = ph[26:0];
        end
      end else begin
        // Counter mode: 50 percent pulses at the selected speed
        next_s.phase[c] = '0;
        case (s.gen[c])
          pio_pkg::PIO_GEN_IDLE: begin
            next_s.pout[c]     = 1'b0;
            next_s.half_cnt[c] = '0;
            if (s.pending[c] != '0) begin
              next_s.pending[c] = s.pending[c] - 32'h1;
              next_s.pout[c]    = 1'b1;
              next_s.gen[c]     = pio_pkg::PIO_GEN_HIGH;
            end
          end
          pio_pkg::PIO_GEN_HIGH: begin
            next_s.half_cnt[c] = s.half_cnt[c] + 32'h1;
            if (s.half_cnt[c] >= half) begin
              next_s.half_cnt[c] = '0;
              next_s.pout[c]     = 1'b0;
              next_s.gen[c]      = pio_pkg::PIO_GEN_LOW;
            end
          end
          pio_pkg::PIO_GEN_LOW: begin
            next_s.half_cnt[c] = s.half_cnt[c] + 32'h1;
            if (s.half_cnt[c] >= half) begin
              next_s.half_cnt[c] = '0;
              next_s.gen[c]      = pio_pkg::PIO_GEN_IDLE;
            end
          end
          default: begin
            next_s.gen[c]  = pio_pkg::PIO_GEN_IDLE;
            next_s.pout[c] = 1'b0;
          end
        endcase
      end
    end

    // Register writes
    if (wr_go) begin
      next_s.bvalid = 1'b1;
      if (wa == `PIO_DOUT) begin
        whit            = 1'b1;
        next_s.dout_reg = axi_req.wstrb[0] ? axi_req.wdata[7:0] : s.dout_reg;
      end
      if (wa == `PIO_CTRL) begin
        whit        = 1'b1;
        next_s.ctrl = axi_req.wstrb[0] ? axi_req.wdata[7:0] : s.ctrl;
      end
      if (wa == `PIO_COIL) begin
        whit        = 1'b1;
        next_s.coil = axi_req.wstrb[0] ? axi_req.wdata[1:0] : s.coil;
        for (int c = 0; c < 2; c++) begin
          // Only a 0 to 1 change of the coil clears; a held 1 does not
          if (next_s.coil[c] && !s.coil[c]) begin
            next_s.in_lsw[c]  = '0;
            next_s.in_msw[c]  = '0;
          end
        end
      end
      if (wa == `PIO_STAT) begin
        whit = 1'b1;
      end
      for (int a = 0; a < 4; a++) begin
        if (wa == 8'(`PIO_AOUT_BASE + a * `PIO_AN_STRIDE)) begin
          whit               = 1'b1;
          next_s.aout_reg[a] = merge16(s.aout_reg[a], axi_req.wdata,
                                       axi_req.wstrb);
        end
        if (wa == 8'(`PIO_AIN_BASE + a * `PIO_AN_STRIDE)) begin
          whit = 1'b1;
        end
      end
      for (int c = 0; c < 2; c++) begin
        base = 8'(`PIO_IN_BASE + c * `PIO_CH_STRIDE);
        if (wa == base + `PIO_OFS_LSW || wa == base + `PIO_OFS_MSW) begin
          whit = 1'b1;
        end
        base = 8'(`PIO_OUT_BASE + c * `PIO_CH_STRIDE);
        if (wa == base + `PIO_OFS_OPL) begin
          whit            = 1'b1;
          next_s.op_lsw[c] = merge16(s.op_lsw[c], axi_req.wdata,
                                     axi_req.wstrb);
        end
        if (wa == base + `PIO_OFS_OPM) begin
          whit            = 1'b1;
          next_s.op_msw[c] = merge16(s.op_msw[c], axi_req.wdata,
                                     axi_req.wstrb);
        end
        if (wa == base + `PIO_OFS_MSW) begin
          whit = 1'b1;
          // Upper word only staged; frequency mode drops it
          if (!s.ctrl[`PIO_C_OUTFREQ + c]) begin
            next_s.out_msw[c] = merge16(s.out_msw[c], axi_req.wdata,
                                        axi_req.wstrb);
          end
        end
        if (wa == base + `PIO_OFS_LSW) begin
          whit              = 1'b1;
          wl                = merge16(s.out_lsw[c], axi_req.wdata, axi_req.wstrb);
          next_s.out_lsw[c] = wl;
          // Lower word commits the pair staged in the upper word
          newc = {s.out_msw[c], wl};
          if (!s.ctrl[`PIO_C_OUTFREQ + c]) begin
            if (s.out_msw[c] == `PIO_CLR_MSW && wl == '0) begin
              next_s.pending[c] = '0;
              next_s.prev[c]    = '0;
              next_s.out_msw[c] = '0;
            end else if (s.op_lsw[c] == `PIO_DIFF_LSW && s.op_msw[c] == '0) begin
              next_s.pending[c] = next_s.pending[c] + newc;
              next_s.prev[c]    = newc;
            end else begin
              // Modulo subtraction wraps a smaller count through zero
              next_s.pending[c] = next_s.pending[c]
                                  + (newc - s.prev[c]);
              next_s.prev[c]    = newc;
            end
          end
        end
      end
      next_s.bresp = whit ? `PIO_RESP_OK : `PIO_RESP_ERR;
    end

    // Register reads
    if (rd_go) begin
      next_s.rvalid = 1'b1;
      next_s.rdata  = '0;
      if (ra == `PIO_DOUT) begin
        rhit         = 1'b1;
        next_s.rdata = {24'h0, s.dout_reg};
      end
      if (ra == `PIO_CTRL) begin
        rhit         = 1'b1;
        next_s.rdata = {24'h0, s.ctrl};
      end
      if (ra == `PIO_COIL) begin
        rhit         = 1'b1;
        next_s.rdata = {30'h0, s.coil};
      end
      if (ra == `PIO_STAT) begin
        rhit         = 1'b1;
        next_s.rdata = {26'h0, s.pout, out_power_ok, backup_ok, primary_ok, link_ok};
      end
      for (int a = 0; a < 4; a++) begin
        if (ra == 8'(`PIO_AOUT_BASE + a * `PIO_AN_STRIDE)) begin
          rhit         = 1'b1;
          next_s.rdata = {16'h0, s.aout_reg[a]};
        end
        if (ra == 8'(`PIO_AIN_BASE + a * `PIO_AN_STRIDE)) begin
          rhit         = 1'b1;
          next_s.rdata = {16'h0, ain[a]};
        end
      end
      for (int c = 0; c < 2; c++) begin
        base = 8'(`PIO_IN_BASE + c * `PIO_CH_STRIDE);
        if (ra == base + `PIO_OFS_LSW) begin
          rhit         = 1'b1;
          next_s.rdata = {16'h0, s.ctrl[`PIO_C_INFREQ + c] ? s.in_freq[c]
                                                            : s.in_lsw[c]};
        end
        if (ra == base + `PIO_OFS_MSW) begin
          rhit         = 1'b1;
          next_s.rdata = {16'h0, s.ctrl[`PIO_C_INFREQ + c] ? 16'h0 : s.in_msw[c]};
        end
        base = 8'(`PIO_OUT_BASE + c * `PIO_CH_STRIDE);
        if (ra == base + `PIO_OFS_LSW) begin
          rhit         = 1'b1;
          next_s.rdata = {16'h0, s.out_lsw[c]};
        end
        if (ra == base + `PIO_OFS_MSW) begin
          rhit         = 1'b1;
          next_s.rdata = {16'h0, s.out_msw[c]};
        end
        if (ra == base + `PIO_OFS_OPL) begin
          rhit         = 1'b1;
          next_s.rdata = {16'h0, s.op_lsw[c]};
        end
        if (ra == base + `PIO_OFS_OPM) begin
          rhit         = 1'b1;
          next_s.rdata = {16'h0, s.op_msw[c]};
        end
      end
      next_s.rresp = rhit ? `PIO_RESP_OK : `PIO_RESP_ERR;
    end
    // Upper address bits must be zero for an OK answer; a write still lands, a read returns zero
    if (wr_go && axi_req.awaddr[31:8] != '0) begin
      next_s.bresp = `PIO_RESP_ERR;
    end
    if (rd_go && axi_req.araddr[31:8] != '0) begin
      next_s.rresp = `PIO_RESP_ERR;
      next_s.rdata = '0;
    end

    // Output drivers: follow registers while the link is up
    for (int d = 0; d < 8; d++) begin
      if (link_ok) begin
        next_s.dout[d] = next_s.dout_reg[d];
      end else if (dout_fail_open[d]) begin
        next_s.dout[d] = 1'b0;
      end
    end
    for (int a = 0; a < 4; a++) begin
      if (link_ok) begin
        next_s.aout[a] = next_s.aout_reg[a];
      end else if (aout_fail_low[a]) begin
        next_s.aout[a] = `PIO_AOUT_FAIL;
      end
    end
  end

  // State register, synchronous active-low reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

endmodule : pio_top

// file: pkg/pio_cfg.svh
`ifndef PIO_CFG_SVH
`define PIO_CFG_SVH
// Clock rate
`define PIO_CLK_MHZ      100
`define PIO_CLK_HZ       27'h5f5e100
// Qualification and generation times, in their own units
`define PIO_HS_MIN_US    10
`define PIO_LS_MIN_MS    70
`define PIO_WINDOW_S     1
`define PIO_HS_OUT_HZ    10000
`define PIO_LS_OUT_HZ    10
// Derived cycle counts
`define PIO_HS_MIN_CYC   (`PIO_HS_MIN_US * `PIO_CLK_MHZ)
`define PIO_LS_MIN_CYC   (`PIO_LS_MIN_MS * `PIO_CLK_MHZ * 1000)
`define PIO_WINDOW_CYC   (`PIO_WINDOW_S * `PIO_CLK_MHZ * 1000000)
`define PIO_HS_HALF_CYC  ((`PIO_CLK_MHZ * 1000000) / (2 * `PIO_HS_OUT_HZ))
`define PIO_LS_HALF_CYC  ((`PIO_CLK_MHZ * 1000000) / (2 * `PIO_LS_OUT_HZ))
// Register byte addresses
`define PIO_DOUT         8'h00
`define PIO_CTRL         8'h04
`define PIO_COIL         8'h08
`define PIO_STAT         8'h0c
`define PIO_AOUT_BASE    8'h10
`define PIO_AIN_BASE     8'h20
`define PIO_IN_BASE      8'h30
`define PIO_OUT_BASE     8'h50
`define PIO_CH_STRIDE    8'h10
`define PIO_AN_STRIDE    8'h04
// Offsets inside a channel block
`define PIO_OFS_LSW      8'h00
`define PIO_OFS_MSW      8'h04
`define PIO_OFS_OPL      8'h08
`define PIO_OFS_OPM      8'h0c
// Control register fields
`define PIO_C_INFREQ     0
`define PIO_C_INHS       2
`define PIO_C_OUTFREQ    4
`define PIO_C_OUTHS      6
// Special values
`define PIO_CLR_MSW      16'h8000
`define PIO_CNT_MAX      16'h7fff
`define PIO_DIFF_LSW     16'h0001
`define PIO_AOUT_FAIL    16'h0ba3
`define PIO_RESP_OK      2'h0
`define PIO_RESP_ERR     2'h2
`endif

// file: pkg/pio_pkg.sv
package pio_pkg;
  // Bus requests from the master
  typedef struct packed {
    logic [31:0] awaddr;
    logic        awvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        bready;
    logic [31:0] araddr;
    logic        arvalid;
    logic        rready;
  } pio_axi_req_t;
  // Bus answers to the master
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } pio_axi_rsp_t;
  // Pulse output generator states
  typedef enum logic [1:0] {
    PIO_GEN_IDLE = 2'b00,
    PIO_GEN_HIGH = 2'b01,
    PIO_GEN_LOW  = 2'b11
  } pio_gen_t;
  // Whole block state
  typedef struct packed {
    logic             bvalid;
    logic [1:0]       bresp;
    logic             rvalid;
    logic [1:0]       rresp;
    logic [31:0]      rdata;
    logic [7:0]       dout_reg;
    logic [7:0]       dout;
    logic [3:0][15:0] aout_reg;
    logic [3:0][15:0] aout;
    logic [7:0]       ctrl;
    logic [1:0]       coil;
    logic [1:0]       in_lvl;
    logic [1:0][31:0] in_flt;
    logic [1:0][15:0] in_lsw;
    logic [1:0][15:0] in_msw;
    logic [1:0][15:0] in_facc;
    logic [1:0][15:0] in_freq;
    logic [31:0]      sec_cnt;
    logic [1:0][15:0] out_lsw;
    logic [1:0][15:0] out_msw;
    logic [1:0][15:0] op_lsw;
    logic [1:0][15:0] op_msw;
    logic [1:0][31:0] prev;
    logic [1:0][31:0] pending;
    logic [1:0][31:0] half_cnt;
    logic [1:0][26:0] phase;
    pio_gen_t [1:0]   gen;
    logic [1:0]       pout;
  } pio_state_t;
endpackage : pio_pkg

// file: sim/pio_pulse_src.sv
`timescale 1ns/1ps
// Field pulse source standing on a pulse input pin
module pio_pulse_src (
  input  wire logic aclk,
  output logic      level
);
  initial level = 1'b0;  // Line rests low between bursts

  // Sends n pulses, w cycles high and w+1 low between them; short w mimics contact bounce
  task automatic burst(input int n, input int w);
    repeat (n) begin
      @(posedge aclk);
      level <= 1'b1;
      repeat (w) @(posedge aclk);
      level <= 1'b0;
      repeat (w) @(posedge aclk);
    end
  endtask : burst
endmodule : pio_pulse_src

// file: sim/pio_top_asserts.sv
`timescale 1ns/1ps
`include "pio_cfg.svh"
module pio_top_asserts #(
  parameter int HS_HALF_CYC = 4  // Shortest counter half period
) (
  input wire logic                  aclk,
  input wire logic                  aresetn,
  input wire pio_pkg::pio_axi_req_t axi_req,
  input wire pio_pkg::pio_axi_rsp_t axi_rsp,
  input wire logic                  out_power_ok,
  input wire logic                  link_ok,
  input wire logic [7:0]            dout_fail_open,
  input wire logic [3:0]            aout_fail_low,
  input wire logic [1:0]            pulse_out,
  input wire logic [7:0]            dout,
  input wire logic [3:0][15:0]      aout
);
  logic [31:0] hi_cnt;  // High run of the first pulse output
  logic        w_take;  // Write taken this edge
  logic        r_take;  // Read taken this edge
  assign w_take = axi_req.awvalid && axi_req.wvalid && !axi_rsp.bvalid;
  assign r_take = axi_req.arvalid && !axi_rsp.rvalid;

  // Run length is judged at the fall, since mode is not visible here
  always_ff @(posedge aclk) begin
    if (!aresetn) hi_cnt <= '0;
    else if (pulse_out[0]) hi_cnt <= hi_cnt + 32'h1;
    else hi_cnt <= '0;
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_b_answer; w_take |=> axi_rsp.bvalid; endproperty
  property p_b_once; $rose(axi_rsp.bvalid) && axi_req.bready |=> !axi_rsp.bvalid; endproperty
  property p_r_answer; r_take |=> axi_rsp.rvalid; endproperty
  property p_r_once; $rose(axi_rsp.rvalid) && axi_req.rready |=> !axi_rsp.rvalid; endproperty
  property p_unmapped;
    r_take && axi_req.araddr == 32'hf0 |=> axi_rsp.rresp == `PIO_RESP_ERR && axi_rsp.rdata == 32'h0;
  endproperty
  property p_dout_wr;
    (w_take && axi_req.awaddr == 32'h0 && axi_req.wstrb[0] && link_ok) ##1 link_ok
      |=> dout == $past(axi_req.wdata[7:0], 2);
  endproperty
  property p_dout_fail; !link_ok |=> (dout & $past(dout_fail_open)) == 8'h00; endproperty
  property p_aout_fail; !link_ok && aout_fail_low[0] |=> aout[0] == `PIO_AOUT_FAIL; endproperty
  property p_pout_off; !out_power_ok |=> pulse_out == 2'h0; endproperty
  property p_hi_width; $fell(pulse_out[0]) |-> hi_cnt >= HS_HALF_CYC; endproperty

  a_b_answer: assert property (p_b_answer) else $error("write not answered next cycle");
  a_b_once: assert property (p_b_once) else $error("write answer repeated");
  a_r_answer: assert property (p_r_answer) else $error("read not answered next cycle");
  a_r_once: assert property (p_r_once) else $error("read answer repeated");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
  a_dout_wr: assert property (p_dout_wr) else $error("digital output missed write");
  a_dout_fail: assert property (p_dout_fail) else $error("digital output not off");
  a_aout_fail: assert property (p_aout_fail) else $error("analog fail code wrong");
  a_pout_off: assert property (p_pout_off) else $error("pulse without power");
  a_hi_width: assert property (p_hi_width) else $error("pulse high too short");

  c_write: cover property (w_take);
  c_pulse: cover property ($rose(pulse_out[0]));
  c_link: cover property (!link_ok);
endmodule : pio_top_asserts

bind pio_top pio_top_asserts #(.HS_HALF_CYC(HS_HALF_CYC)) u_chk (
  .aclk(aclk), .aresetn(aresetn), .axi_req(axi_req), .axi_rsp(axi_rsp),
  .out_power_ok(out_power_ok), .link_ok(link_ok), .dout_fail_open(dout_fail_open),
  .aout_fail_low(aout_fail_low), .pulse_out(pulse_out), .dout(dout), .aout(aout));

// file: sim/pio_top_test.sv
`timescale 1ns/1ps
`include "pio_cfg.svh"
module pio_top_test;
  localparam int         HS  = 4;              // Shortened 10 kHz half period
  localparam int         PP  = 2 * HS + 1;     // Cycles per emitted pulse
  localparam logic [7:0] IN  = `PIO_IN_BASE;   // Input channel 0 block
  localparam logic [7:0] OUT = `PIO_OUT_BASE;  // Output channel 0 block
  logic                  aclk = 1'b0;
  logic                  aresetn = 1'b0;
  pio_pkg::pio_axi_req_t req = '0;
  pio_pkg::pio_axi_rsp_t rsp;
  wire  [1:0]            pin;
  logic                  primary_ok = 1'b1;
  logic                  backup_ok = 1'b0;
  logic                  out_power_ok = 1'b1;
  logic                  link_ok = 1'b1;
  logic [1:0]            pulse_out;
  logic [7:0]            dout;
  logic [3:0][15:0]      aout;
  int                    mismatches = 0;
  int                    samples_checked = 0;
  int                    rises = 0;   // Rising edges on pulse output 0
  int                    base;
  logic                  pout_q = 1'b0;
  logic [31:0]           rd_data;
  logic [1:0]            rd_resp;

  always #5 aclk = ~aclk;

  pio_pulse_src u_src0 (.aclk(aclk), .level(pin[0]));
  pio_pulse_src u_src1 (.aclk(aclk), .level(pin[1]));

  pio_top #(.LS_MIN_CYC(10), .WINDOW_CYC(200), .HS_HALF_CYC(HS), .LS_HALF_CYC(8)) u_dut (
    .aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp), .pulse_in(pin),
    .primary_ok(primary_ok), .backup_ok(backup_ok), .out_power_ok(out_power_ok),
    .link_ok(link_ok), .dout_fail_open(8'h0f), .aout_fail_low(4'h1),
    .ain({16'h0004, 16'h0003, 16'h0002, 16'h7fff}), .pulse_out(pulse_out),
    .dout(dout), .aout(aout));

  // Edge counter; compared as differences so it never needs clearing
  always @(posedge aclk) begin
    pout_q <= pulse_out[0];
    if (pulse_out[0] === 1'b1 && pout_q === 1'b0) rises <= rises + 1;
  end

  task automatic final_report();
    if (mismatches == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : final_report

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Bounded wait: 0 write taken, 1 bvalid, 2 read taken, 3 rvalid
  task automatic wait_for(input int sel);
    int   n;
    logic hit;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      hit = sel == 0 ? rsp.awready : sel == 1 ? rsp.bvalid : sel == 2 ? rsp.arready : rsp.rvalid;
    end while (hit !== 1'b1 && n < 100);
    if (hit !== 1'b1) begin
      mismatches++;
      final_report();
    end
  endtask : wait_for

  // Address and data go out together; bready rests high throughout
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    req.awaddr <= {24'h0, a};
    req.wdata <= {16'h0, d};
    req.wstrb <= 4'h3;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    wait_for(0);
    req.awvalid <= 1'b0;
    req.wvalid <= 1'b0;
    wait_for(1);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    req.araddr <= {24'h0, a};
    req.arvalid <= 1'b1;
    wait_for(2);
    req.arvalid <= 1'b0;
    wait_for(3);
    rd_data = rsp.rdata;
    rd_resp = rsp.rresp;
    check($sformatf("reg %h", a), rd_data, exp);
  endtask : rd_chk

  initial begin
    req.bready <= 1'b1;
    req.rready <= 1'b1;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    wr(`PIO_DOUT, 16'h00a5);
    repeat (3) @(posedge aclk);
    check("dout", {24'h0, dout}, 32'ha5);
    wr(`PIO_AOUT_BASE, 16'h5d17);
    repeat (3) @(posedge aclk);
    check("aout0", {16'h0, aout[0]}, 32'h5d17);
    rd_chk(`PIO_AIN_BASE, 32'h7fff);
    rd_chk(8'hf0, 32'h0);
    check("rresp", {30'h0, rd_resp}, {30'h0, `PIO_RESP_ERR});
    link_ok <= 1'b0;
    repeat (3) @(posedge aclk);
    check("dout fail", {24'h0, dout}, 32'ha0);
    check("aout fail", {16'h0, aout[0]}, {16'h0, `PIO_AOUT_FAIL});
    link_ok <= 1'b1;
    // Inputs count at low speed, outputs count at high speed
    wr(`PIO_CTRL, 16'h00c0);
    fork
      u_src0.burst(3, 30);
      u_src1.burst(3, 5);
    join
    repeat (30) @(posedge aclk);
    rd_chk(IN, 32'h3);
    rd_chk(IN + 8'h04, 32'h0);
    rd_chk(IN + `PIO_CH_STRIDE, 32'h0);
    wr(`PIO_COIL, 16'h0001);
    rd_chk(IN, 32'h0);
    u_src0.burst(2, 30);
    repeat (30) @(posedge aclk);
    wr(`PIO_COIL, 16'h0001);
    rd_chk(IN, 32'h2);
    primary_ok <= 1'b0;
    u_src0.burst(2, 30);
    repeat (30) @(posedge aclk);
    rd_chk(IN, 32'h2);
    backup_ok <= 1'b1;
    u_src0.burst(1, 30);
    repeat (30) @(posedge aclk);
    rd_chk(IN, 32'h3);
    wr(OUT + 8'h08, 16'h0001);
    wr(OUT + 8'h0c, 16'h0000);
    base = rises;
    wr(OUT + 8'h04, 16'h0000);
    wr(OUT, 16'h0003);
    wr(OUT, 16'h0002);
    repeat (5 * PP + 20) @(posedge aclk);
    check("diff pulses", rises - base, 5);
    wr(OUT + 8'h04, `PIO_CLR_MSW);
    wr(OUT, 16'h0000);
    rd_chk(OUT + 8'h04, 32'h0);
    wr(OUT + 8'h08, 16'h0000);
    base = rises;
    wr(OUT, 16'h0005);
    repeat (5 * PP + 20) @(posedge aclk);
    check("abs pulses", rises - base, 5);
    wr(OUT, 16'h0007);
    repeat (2 * PP + 20) @(posedge aclk);
    check("abs step", rises - base, 7);
    wr(OUT, 16'h0010);
    repeat (3) @(posedge aclk);
    out_power_ok <= 1'b0;
    repeat (5) @(posedge aclk);
    check("pout off", {30'h0, pulse_out}, 32'h0);
    out_power_ok <= 1'b1;
    repeat (120) @(posedge aclk);
    // Frequency mode on output 0: upper word writes are dropped
    wr(`PIO_CTRL, 16'h00d0);
    wr(OUT + 8'h04, 16'h1234);
    rd_chk(OUT + 8'h04, 32'h0);
    // Input 0 in frequency mode: a 25-cycle period gives 8 edges per 200-cycle gate
    wr(`PIO_CTRL, 16'h00d1);
    fork
      u_src0.burst(24, 12);
      begin
        repeat (450) @(posedge aclk);
        rd_chk(IN, 32'h8);
      end
    join
    final_report();
  end
endmodule : pio_top_test
